//--- pcpr_regs.svh
// Register offsets, field positions and reset values of the control bank
`ifndef PCPR_REGS_SVH
`define PCPR_REGS_SVH
`define PCPR_OFF_PAGE       8'h00
`define PCPR_OFF_SRESET     8'h01
`define PCPR_OFF_POWER1     8'h04
`define PCPR_OFF_CAUSE1     8'h68
`define PCPR_OFF_CAUSE2     8'h6c
`define PCPR_OFF_BOOK       8'h7f
`define PCPR_RST_PAGE       8'h00
`define PCPR_RST_BOOK       8'h00
`define PCPR_RST_POWER1     8'h00
`define PCPR_RST_CAUSE      8'h00
`define PCPR_BIT_DSP        7
`define PCPR_BIT_PLL        6
`define PCPR_BIT_NDIV       5
`define PCPR_BIT_PDAC       4
`define PCPR_BIT_SADC       3
`define PCPR_BIT_FAULT      0
`define PCPR_BIT_SRESET     0
`define PCPR_BIT_BROWNOUT   0
`define PCPR_BIT_CLKHALT    1
`define PCPR_BOOK_ZERO      8'h00
`define PCPR_PAGE_ZERO      8'h00
`endif

//--- pcpr_pkg.sv
// Types shared by the paged control and power register bank
package pcpr_pkg;
  // Register access request from the serial control port front end
  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } pcpr_req_t;

  // Block power enables driven to the analog and clock blocks
  typedef struct packed {
    logic dsp_power_on;
    logic freq_synth_power_on;
    logic feedback_divider_power_on;
    logic playback_converter_clock_power_on;
    logic sense_converter_clock_power_on;
  } pcpr_pwr_t;

  // Whole state of the register bank
  typedef struct packed {
    logic [7:0] page_select;
    logic [7:0] book_select;
    logic [7:0] power_control_one;
    logic [7:0] fault_cause_one;
    logic [7:0] fault_cause_two;
    logic       soft_reset_pulse;
    logic [7:0] rdata;
    logic       rvalid;
  } pcpr_state_t;
endpackage : pcpr_pkg

//--- pcpr_bank.sv
// Page zero control, software reset and power-up registers of a paged register space
`timescale 1ns/100ps
`default_nettype none
`include "pcpr_regs.svh"
module pcpr_bank
  import pcpr_pkg::*;
(
  input  wire logic       sys_clk,
  input  wire logic       reset,
  input  wire pcpr_req_t  req,
  input  wire logic       brownout_det,
  input  wire logic       clock_halt_det,
  output logic [7:0]      rdata,
  output logic            rvalid,
  output logic [7:0]      page_sel,
  output logic [7:0]      book_sel,
  output logic            ext_access,
  output logic            soft_reset_out,
  output pcpr_pwr_t       pwr,
  output logic            power_fault_flag
);

  // ****************************************************************
  // Behaviour notes
  // ****************************************************************

  // Access model: the serial front end hands over one byte access per strobe.
  // A read answers with rvalid and rdata exactly one cycle later. rdata is zero
  // whenever rvalid is low, so downstream logic may OR several banks together.
  // A write becomes visible on the outputs right after its taking edge.
  //
  // Paging: only book 0 page 0 belongs to this bank. On any other page the bank
  // still answers offset 0 so the host can get back to page 0, though a nonzero book clears only on reset, and ext_access tells
  // the other banks that the access is theirs. Reads elsewhere return zero and
  // writes are dropped, which keeps two banks from answering one offset.
  //
  // Fault handling: a brownout or clock halt in any cycle but a reset pulse cycle sets the fault flag,
  // records its cause and drops every enable in the same update. The set wins
  // over a host write that clears the flag in that cycle, because losing a fault
  // would leave the analog blocks powered on a failing supply.
  //
  // Enable gating: whenever the flag is one after an update, the enables are held
  // low, whatever the host wrote. The host clears the flag with one write and
  // powers up with the next. A single write that clears the flag and sets enables
  // is honoured too, since the flag is then zero. A host that writes one to the
  // flag bit itself gets the same gating, so the flag never sits beside live
  // enables.
  //
  // Reserved bits 2 and 1 of the power control byte are plain storage: they read
  // back what was written and reset to zero, and nothing else uses them.
  //
  // Cause registers: brownout is bit 0 at 0x68 and clock halt bit 1 at 0x6C. Both
  // clear by writing one to the bit, and a new event in the same cycle wins.
  //
  // Software reset: the trigger bit is never stored. It becomes a one-cycle pulse
  // on soft_reset_out and the restore happens on the following edge. That edge
  // overrides every fault event and every write but a new trigger seen in that cycle, so the bank always
  // leaves a software reset in its reset state. Read answers are not restored.
  //
  // Limitation: fault inputs are taken as synchronous levels; a source in another
  // clock domain must be synchronised before it reaches this bank.

  // ****************************************************************
  // Address decode
  // ****************************************************************

  pcpr_state_t st_r;
  pcpr_state_t st_nxt;
  logic        local_page;

  // True when an offset hits a register of this bank on book 0 page 0
  function automatic logic hit(input logic [7:0] a, input logic [7:0] off, input logic lp);
    hit = lp && (a == off);
  endfunction : hit

  // Power control byte with every enable forced low and the other bits kept;
  // shared by the fault power-down and the flag gating so both drop the same set
  function automatic logic [7:0] drop_enables(input logic [7:0] v);
    drop_enables                      = v;
    drop_enables[`PCPR_BIT_DSP]  = 1'b0;
    drop_enables[`PCPR_BIT_PLL]  = 1'b0;
    drop_enables[`PCPR_BIT_NDIV] = 1'b0;
    drop_enables[`PCPR_BIT_PDAC] = 1'b0;
    drop_enables[`PCPR_BIT_SADC] = 1'b0;
  endfunction : drop_enables

  // page steers decode
  // Page 0 of book 0 is local; the page register itself stays reachable on every page,
  // because each page carries its own selector at offset 0.
  assign local_page = (st_r.page_select == `PCPR_PAGE_ZERO) &&
                      (st_r.book_select == `PCPR_BOOK_ZERO);

  // ****************************************************************
  // Next-state logic
  // ****************************************************************

  // One combinational pass builds the next copy of the whole bank state
  always_comb begin
    logic [7:0] p1;
    logic       fault_now;
    p1        = st_r.power_control_one;
    fault_now = brownout_det || clock_halt_det;
    st_nxt = st_r;
    st_nxt.soft_reset_pulse = 1'b0;
    st_nxt.rvalid = req.rd;
    st_nxt.rdata  = 8'h00;
    // Read answer, registered so it lines up with rvalid one cycle later
    if (req.rd) begin
      if (req.addr == `PCPR_OFF_PAGE) begin
        st_nxt.rdata = st_r.page_select;
      end else if (hit(req.addr, `PCPR_OFF_POWER1, local_page)) begin
        st_nxt.rdata = st_r.power_control_one;
      end else if (hit(req.addr, `PCPR_OFF_CAUSE1, local_page)) begin
        st_nxt.rdata = st_r.fault_cause_one;
      end else if (hit(req.addr, `PCPR_OFF_CAUSE2, local_page)) begin
        st_nxt.rdata = st_r.fault_cause_two;
      end else if (hit(req.addr, `PCPR_OFF_BOOK, local_page)) begin
        st_nxt.rdata = st_r.book_select;
      end else begin
        st_nxt.rdata = 8'h00; // Soft reset and unmapped offsets read zero
      end
    end
    // Host writes; events and the software reset below may still override them
    if (req.wr) begin
      if (req.addr == `PCPR_OFF_PAGE) begin
        st_nxt.page_select = req.wdata;
      end
      if (hit(req.addr, `PCPR_OFF_BOOK, local_page)) begin
        st_nxt.book_select = req.wdata;
      end
      if (hit(req.addr, `PCPR_OFF_SRESET, local_page) && req.wdata[`PCPR_BIT_SRESET]) begin
        st_nxt.soft_reset_pulse = 1'b1;
      end
      if (hit(req.addr, `PCPR_OFF_POWER1, local_page)) begin
        p1 = req.wdata;
      end
      // cause registers clear on write of ones
      if (hit(req.addr, `PCPR_OFF_CAUSE1, local_page)) begin
        st_nxt.fault_cause_one = st_r.fault_cause_one & ~req.wdata;
      end
      if (hit(req.addr, `PCPR_OFF_CAUSE2, local_page)) begin
        st_nxt.fault_cause_two = st_r.fault_cause_two & ~req.wdata;
      end
    end
    // fault sets the flag, winning over a host clear
    if (fault_now) begin
      p1[`PCPR_BIT_FAULT] = 1'b1;
      p1 = drop_enables(p1);
    end
    // enables stay low while the flag is set
    if (p1[`PCPR_BIT_FAULT]) begin
      p1 = drop_enables(p1);
    end
    st_nxt.power_control_one = p1;
    // cause capture, set wins over clear
    if (brownout_det) begin
      st_nxt.fault_cause_one[`PCPR_BIT_BROWNOUT] = 1'b1;
    end
    if (clock_halt_det) begin
      st_nxt.fault_cause_two[`PCPR_BIT_CLKHALT] = 1'b1;
    end
    if (st_r.soft_reset_pulse) begin
      st_nxt.page_select       = `PCPR_RST_PAGE;
      st_nxt.book_select       = `PCPR_RST_BOOK;
      st_nxt.power_control_one = `PCPR_RST_POWER1;
      st_nxt.fault_cause_one   = `PCPR_RST_CAUSE;
      st_nxt.fault_cause_two   = `PCPR_RST_CAUSE;
    end
  end

  // ****************************************************************
  // State register
  // ****************************************************************

  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      st_r.page_select       <= `PCPR_RST_PAGE;
      st_r.book_select       <= `PCPR_RST_BOOK;
      st_r.power_control_one <= `PCPR_RST_POWER1;
      st_r.fault_cause_one   <= `PCPR_RST_CAUSE;
      st_r.fault_cause_two   <= `PCPR_RST_CAUSE;
      st_r.soft_reset_pulse  <= 1'b0;
      st_r.rdata             <= 8'h00;
      st_r.rvalid            <= 1'b0;
    end else begin
      st_r <= st_nxt;
    end
  end

  // Outputs come straight from the state register except ext_access, decoded from page and book
  assign rdata            = st_r.rdata;
  assign rvalid           = st_r.rvalid;
  assign page_sel         = st_r.page_select;
  assign book_sel         = st_r.book_select;
  assign ext_access       = ~local_page;
  assign soft_reset_out   = st_r.soft_reset_pulse;
  assign power_fault_flag = st_r.power_control_one[`PCPR_BIT_FAULT];
  // One driver for the whole carrier, fields in the order the type declares them
  assign pwr = {st_r.power_control_one[`PCPR_BIT_DSP],
                st_r.power_control_one[`PCPR_BIT_PLL],
                st_r.power_control_one[`PCPR_BIT_NDIV],
                st_r.power_control_one[`PCPR_BIT_PDAC],
                st_r.power_control_one[`PCPR_BIT_SADC]};

endmodule : pcpr_bank
`default_nettype wire

//--- pcpr_bank_properties.sv
// Port checks of the control and power register bank
`timescale 1ns/100ps
`default_nettype none
module pcpr_bank_properties
  import pcpr_pkg::*;
(
  input wire logic       sys_clk,
  input wire logic       reset,
  input wire pcpr_req_t  req,
  input wire logic       brownout_det,
  input wire logic       clock_halt_det,
  input wire logic [7:0] rdata,
  input wire logic       rvalid,
  input wire logic [7:0] page_sel,
  input wire logic [7:0] book_sel,
  input wire logic       ext_access,
  input wire logic       soft_reset_out,
  input wire pcpr_pwr_t  pwr,
  input wire logic       power_fault_flag
);
  default clocking @(posedge sys_clk);
  endclocking
  default disable iff (reset);
  // Strobes; a reset pulse cycle loses every write but a new trigger, so those are left out
  wire logic ok  = !ext_access && !soft_reset_out;
  wire logic evt = brownout_det || clock_halt_det;
  wire logic wp  = req.wr && req.addr == 8'h00 && !soft_reset_out;
  wire logic rp  = req.rd && req.addr == 8'h00;
  wire logic wr1 = req.wr && req.addr == 8'h01 && ok;
  wire logic wpw = req.wr && req.addr == 8'h04 && ok && !req.wdata[0] && !evt;
  // Pulse, then page select and enables back at zero
  sequence clean_s;
    soft_reset_out ##1 !soft_reset_out && page_sel == 8'h00 && pwr == '0;
  endsequence
  page_load_a: assert property (wp |=> page_sel == $past(req.wdata)) else $error("page");
  page_read_a: assert property (rp |=> rvalid && rdata == $past(page_sel)) else $error("rd");
  soft_reset_a: assert property (wr1 && req.wdata[0] |=> clean_s) else $error("sreset");
  reset_ignore_a: assert property (wr1 && !req.wdata[0] |=> !soft_reset_out) else $error("s0");
  fault_set_a:
    assert property (evt && !soft_reset_out |=> power_fault_flag && pwr == '0) else $error("fault");
  fault_gate_a: assert property (power_fault_flag |-> pwr == '0) else $error("gate");
  power_write_a: assert property (wpw |=> pwr == $past(req.wdata[7:3])) else $error("pwr");
  ext_flag_a:
    assert property (ext_access == (page_sel != 8'h00 || book_sel != 8'h00)) else $error("ext");
endmodule : pcpr_bank_properties
bind pcpr_bank pcpr_bank_properties u_props (.sys_clk(sys_clk), .reset(reset), .req(req),
  .brownout_det(brownout_det), .clock_halt_det(clock_halt_det), .rdata(rdata), .rvalid(rvalid),
  .page_sel(page_sel), .book_sel(book_sel), .ext_access(ext_access),
  .soft_reset_out(soft_reset_out), .pwr(pwr), .power_fault_flag(power_fault_flag));
`default_nettype wire

//--- pcpr_host_model.sv
// Host processor model issuing single-byte accesses
`timescale 1ns/100ps
`default_nettype none
module pcpr_host_model
  import pcpr_pkg::*;
(
  input  wire logic       sys_clk,
  input  wire logic [7:0] rdata,
  input  wire logic       rvalid,
  output var pcpr_req_t   req
);
  initial req = '0;
  // Strobe held for one taking edge; released fields flip so stale data is never trusted
  task automatic write(input logic [7:0] a, input logic [7:0] d);
    @(posedge sys_clk) #1 req = '{1'b1, 1'b0, a, d};
    @(posedge sys_clk) #1 req = '{1'b0, 1'b0, ~a, ~d};
  endtask : write
  // Answer stands one cycle only, so it is taken right after the taking edge
  task automatic read(input logic [7:0] a, output logic [7:0] d);
    @(posedge sys_clk) #1 req = '{1'b0, 1'b1, a, 8'h5a};
    @(posedge sys_clk) #1 req = '{1'b0, 1'b0, ~a, 8'ha5};
    d = (rvalid === 1'b1) ? rdata : 8'hxx;
  endtask : read
  task automatic recover(input logic [7:0] d);
    write(8'h04, 8'h00);
    write(8'h04, d);
  endtask : recover
endmodule : pcpr_host_model
`default_nettype wire

//--- tb_paged_control_power_regs.sv
// Self-checking bench for the control and power register bank
`timescale 1ns/100ps
`default_nettype none
module tb_paged_control_power_regs;
  import pcpr_pkg::*;
  logic       sys_clk, reset, brownout_det, clock_halt_det, rvalid, ext_access, sro, flag;
  logic [7:0] rdata, page_sel, book_sel, d;
  logic [7:0] offs [6] = '{8'h00, 8'h01, 8'h04, 8'h68, 8'h6c, 8'h7f};
  wire pcpr_req_t req;
  pcpr_pwr_t  pwr;
  int         error_cnt = 0;
  int         tests_run = 0;
  pcpr_bank u_dut (.sys_clk(sys_clk), .reset(reset), .req(req), .brownout_det(brownout_det),
    .clock_halt_det(clock_halt_det), .rdata(rdata), .rvalid(rvalid), .page_sel(page_sel),
    .book_sel(book_sel), .ext_access(ext_access), .soft_reset_out(sro), .pwr(pwr),
    .power_fault_flag(flag));
  pcpr_host_model u_host (.sys_clk(sys_clk), .rdata(rdata), .rvalid(rvalid), .req(req));
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    tests_run++;
    if (seen !== exp) begin
      error_cnt++;
      $display("unexpected at %0t: saw %h want %h", $time, seen, exp);
    end
  endtask : chk
  task automatic rchk(input logic [7:0] a, input logic [7:0] exp);
    u_host.read(a, d);
    chk(d, exp);
  endtask : rchk
  // One cycle of brownout (bo=1) or clock halt (bo=0)
  task automatic fault(input logic bo);
    @(posedge sys_clk) #1 {brownout_det, clock_halt_det} = {bo, !bo};
    @(posedge sys_clk) #1 {brownout_det, clock_halt_det} = 2'b00;
  endtask : fault
  task automatic final_report;
    $display("comparisons %0d mismatches %0d", tests_run, error_cnt);
    if (error_cnt == 0 && tests_run > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : final_report
  initial begin
    sys_clk = 1'b0;
    forever #20 sys_clk = ~sys_clk;
  end
  // Hang guard
  initial begin
    repeat (5000) @(posedge sys_clk);
    error_cnt++;
    final_report();
  end
  initial begin
    {reset, brownout_det, clock_halt_det} = 3'b100;
    repeat (20) @(posedge sys_clk);
    #1 reset = 1'b0;
    foreach (offs[i]) rchk(offs[i], 8'h00);
    for (int i = 3; i < 8; i++) begin
      u_host.write(8'h04, 8'h01 << i);
      chk({3'h0, pwr}, 8'h01 << (i - 3));
    end
    $display("test enables done");
    u_host.write(8'h04, 8'hf8);
    fault(1'b1);
    chk({2'h0, flag, pwr}, 8'h20);
    rchk(8'h68, 8'h01);
    u_host.write(8'h04, 8'hf9);
    rchk(8'h04, 8'h01);
    fault(1'b0);
    rchk(8'h6c, 8'h02);
    u_host.write(8'h68, 8'h01);
    rchk(8'h68, 8'h00);
    u_host.recover(8'hf8);
    rchk(8'h04, 8'hf8);
    $display("test fault done");
    u_host.write(8'h01, 8'h00);
    chk({2'h0, sro, pwr}, 8'h1f);
    u_host.write(8'h01, 8'h01);
    chk({7'h0, sro}, 8'h01);
    rchk(8'h04, 8'h00);
    rchk(8'h6c, 8'h00);
    $display("test soft reset done");
    u_host.write(8'h00, 8'h02);
    chk({7'h0, ext_access}, 8'h01);
    rchk(8'h04, 8'h00);
    rchk(8'h00, 8'h02);
    u_host.write(8'h00, 8'h00);
    u_host.write(8'h7f, 8'h03);
    chk(book_sel, 8'h03);
    @(posedge sys_clk) #1 reset = 1'b1;
    @(posedge sys_clk) #1 reset = 1'b0;
    chk(book_sel | page_sel, 8'h00);
    $display("test selectors done");
    final_report();
  end
endmodule : tb_paged_control_power_regs
`default_nettype wire
